// >>> inc/lcdc_cfg.svh
// constants for the serial display controller
`ifndef LCDC_CFG_SVH
`define LCDC_CFG_SVH
`define LCDC_ID_READ     3'h6
`define LCDC_ID_WRITE    3'h5
`define LCDC_ID_CMD      3'h4
`define LCDC_ID_BITS     4'h2
`define LCDC_ADDR_LAST   4'h5
`define LCDC_NIB_LAST    4'h3
`define LCDC_CMD_LAST    4'h8
`define LCDC_C_OSC_OFF   4'h0
`define LCDC_C_OSC_ON    4'h1
`define LCDC_C_DISP_OFF  4'h2
`define LCDC_C_DISP_ON   4'h3
`define LCDC_C_TB_OFF    4'h4
`define LCDC_C_DOG_OFF   4'h5
`define LCDC_C_TB_ON     4'h6
`define LCDC_C_DOG_ON    4'h7
`define LCDC_C_TONE_OFF  4'h8
`define LCDC_C_TB_CLR    4'hD
`define LCDC_C_DOG_CLR   4'hF
`define LCDC_G_BASIC     4'h0
`define LCDC_G_BEEP_HI   3'h2
`define LCDC_G_BEEP_LO   4'h6
`define LCDC_G_EVENT     3'h4
`define LCDC_G_RATE      3'h5
`define LCDC_G_MODE      4'hE
`define LCDC_M_TEST      4'h0
`define LCDC_M_NORMAL    4'h3
`define LCDC_RATE_RST    3'h7
`define LCDC_TB_TOP_BIT  4'hE
`define LCDC_BEEP_HI_BIT 4'h2
`define LCDC_BEEP_LO_BIT 4'h3
`define LCDC_DOG_LAST    2'h3
`define LCDC_FIFO_W      10
`define LCDC_FIFO_D      16
`endif

// >>> inc/lcdc_pkg.sv
// types of the serial display controller
`default_nettype none
package lcdc_pkg;
    typedef enum logic [2:0] {ST_ID, ST_ADDR, ST_WR, ST_RD, ST_RMW, ST_CMD, ST_IGN} lcdc_mode_t;
    typedef struct packed {
        lcdc_mode_t      st;
        logic            rdm;
        logic [3:0]      bcnt;
        logic [8:0]      sh;
        logic [5:0]      addr;
        logic [63:0][3:0] ram;
        logic            wr_d;
        logic            rd_d;
        logic            dout;
        logic            doe_n;
        logic            pend_v;
        logic [5:0]      pend_a;
        logic [3:0]      pend_d;
        logic            osc;
        logic            disp;
        logic            tb_en;
        logic            dog_en;
        logic            irq_en;
        logic            tone_en;
        logic            tone_hi;
        logic [2:0]      rate;
        logic            test;
        logic [14:0]     cnt;
        logic            tb_prev;
        logic [1:0]      dog_stg;
        logic            dog_flag;
        logic            irq_n;
        logic            tone_p;
        logic            tone_n;
    } lcdc_state_t;
endpackage
`default_nettype wire

// >>> rtl/lcdc_ctrl.sv
// serial command front end, display memory, timers and tone of the display controller
`include "lcdc_cfg.svh"
`default_nettype none

module lcdc_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         resetn,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wp;
    logic [AW:0]  rp;
    logic         push;
    logic         pop;

    assign in_ready  = (wp[AW-1:0] != rp[AW-1:0]) || (wp[AW] == rp[AW]);
    assign out_valid = (wp != rp);
    assign out_data  = mem[rp[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wp <= '0;
            rp <= '0;
        end
        else
        begin
            if (push)
            begin
                wp <= wp + 1'b1;
            end
            if (pop)
            begin
                rp <= rp + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end
endmodule

module lcdc_ctrl (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         resetn,
    // host serial pins
    input  wire logic         cs_n,
    input  wire logic         wr_n,
    input  wire logic         rd_n,
    input  wire logic         data_i,
    output logic              data_o,
    output logic              data_oe_n,
    // system clock source
    input  wire logic         osc_tick,
    input  wire logic         ext_clk_sel,
    // display side
    output logic [255:0]      disp_ram,
    output logic              disp_on,
    output logic              osc_run,
    output logic              test_mode,
    // tone and interrupt
    output logic              tone_p,
    output logic              tone_n,
    output logic              irq_n
);
    import lcdc_pkg::*;

    function automatic lcdc_state_t rst_val();
        lcdc_state_t r;
        r         = '0;
        r.rate    = `LCDC_RATE_RST;
        r.wr_d    = 1'b1;
        r.rd_d    = 1'b1;
        r.doe_n   = 1'b1;
        r.irq_n   = 1'b1;
        r.tone_n  = 1'b1;
        return r;
    endfunction

    localparam lcdc_state_t ST_RST = rst_val();

    lcdc_state_t                 s;
    lcdc_state_t                 n;
    logic                        wr_rise;
    logic                        rd_fall;
    logic                        run;
    logic                        tb_lvl;
    logic                        drain_rdy;
    logic                        f_in_ready;
    logic                        f_out_valid;
    logic [`LCDC_FIFO_W-1:0]     f_out_data;

    // write words queue here; a read access owns the memory port that cycle
    assign drain_rdy = !rd_fall;

    lcdc_fifo #(
        .W (`LCDC_FIFO_W),
        .D (`LCDC_FIFO_D)
    ) u_fifo (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_valid  (s.pend_v),
        .in_ready  (f_in_ready),
        .in_data   ({s.pend_a, s.pend_d}),
        .out_valid (f_out_valid),
        .out_ready (drain_rdy),
        .out_data  (f_out_data)
    );

    assign wr_rise = wr_n && !s.wr_d;
    assign rd_fall = !rd_n && s.rd_d;
    assign run     = s.osc || ext_clk_sel;
    assign tb_lvl  = s.cnt[4'(`LCDC_TB_TOP_BIT - {1'b0, s.rate})];

    always_comb
    begin
        logic [8:0] c;
        logic [3:0] nib;
        c   = '0;
        nib = '0;
        n   = s;
        n.wr_d = wr_n;
        n.rd_d = rd_n;
        if (f_out_valid && drain_rdy)
        begin
            n.ram[f_out_data[9:4]] = f_out_data[3:0];
        end
        if (s.pend_v && f_in_ready)
        begin
            n.pend_v = 1'b0;
        end
        // shared prescaler and time base chain
        if (osc_tick && run)
        begin
            n.cnt = s.cnt + 15'h0001;
        end
        if (s.st == ST_WR && !wr_n)
        begin
            n.doe_n = 1'b1;
        end
        if (cs_n)
        begin
            n.st    = ST_ID;
            n.bcnt  = '0;
            n.sh    = '0;
            n.doe_n = 1'b1;
        end
        else if (wr_rise)
        begin
            unique case (s.st)
                ST_ID:
                begin
                    n.sh   = {s.sh[7:0], data_i};
                    n.bcnt = s.bcnt + 4'h1;
                    if (s.bcnt == `LCDC_ID_BITS)
                    begin
                        n.bcnt = '0;
                        n.sh   = '0;
                        n.rdm  = ({s.sh[1:0], data_i} == `LCDC_ID_READ);
                        if ({s.sh[1:0], data_i} == `LCDC_ID_READ ||
                            {s.sh[1:0], data_i} == `LCDC_ID_WRITE)
                        begin
                            n.st = ST_ADDR;
                        end
                        else if ({s.sh[1:0], data_i} == `LCDC_ID_CMD)
                        begin
                            n.st = ST_CMD;
                        end
                        else
                        begin
                            n.st = ST_IGN;
                        end
                    end
                end
                ST_ADDR:
                begin
                    n.sh   = {s.sh[7:0], data_i};
                    n.bcnt = s.bcnt + 4'h1;
                    if (s.bcnt == `LCDC_ADDR_LAST)
                    begin
                        n.addr = {s.sh[4:0], data_i};
                        n.bcnt = '0;
                        n.st   = s.rdm ? ST_RD : ST_WR;
                    end
                end
                ST_WR:
                begin
                    n.sh[s.bcnt[1:0]] = data_i;
                    n.bcnt = s.bcnt + 4'h1;
                    if (s.bcnt == `LCDC_NIB_LAST)
                    begin
                        n.pend_v = 1'b1;
                        n.pend_a = s.addr;
                        n.pend_d = {data_i, s.sh[2:0]};
                        n.addr   = s.addr + 6'h01;
                        n.bcnt   = '0;
                    end
                end
                ST_CMD:
                begin
                    n.sh   = {s.sh[7:0], data_i};
                    n.bcnt = s.bcnt + 4'h1;
                    if (s.bcnt == `LCDC_CMD_LAST)
                    begin
                        c      = {s.sh[7:0], data_i};
                        n.bcnt = '0;
                    end
                end
                default:
                begin
                end
            endcase
        end
        else if (rd_fall)
        begin
            if (s.st == ST_RD || s.st == ST_RMW || (s.st == ST_WR && s.bcnt == 4'h0))
            begin
                nib     = s.ram[s.addr];
                n.dout  = nib[s.bcnt[1:0]];
                n.doe_n = 1'b0;
                n.bcnt  = s.bcnt + 4'h1;
                if (s.st == ST_WR)
                begin
                    n.st = ST_RMW;
                end
                if (s.bcnt == `LCDC_NIB_LAST)
                begin
                    n.bcnt = '0;
                    if (s.st == ST_RD)
                    begin
                        n.addr = s.addr + 6'h01;
                    end
                    else
                    begin
                        n.st = ST_WR;
                    end
                end
            end
        end
        // command execution; one flag per control, but a beep also writes tone_hi, watchdog clear also zeroes dog_stg, interrupt disable also clears dog_flag
        if (wr_rise && !cs_n && s.st == ST_CMD && s.bcnt == `LCDC_CMD_LAST)
        begin
            if (c[8:5] == `LCDC_G_BASIC)
            begin
                unique case (c[4:1])
                    `LCDC_C_OSC_OFF:  n.osc = ext_clk_sel ? s.osc : 1'b0;
                    `LCDC_C_OSC_ON:   n.osc = 1'b1;
                    `LCDC_C_DISP_OFF: n.disp = 1'b0;
                    `LCDC_C_DISP_ON:  n.disp = 1'b1;
                    `LCDC_C_TB_OFF:   n.tb_en = 1'b0;
                    `LCDC_C_TB_ON:    n.tb_en = 1'b1;
                    `LCDC_C_DOG_OFF:  n.dog_en = 1'b0;
                    `LCDC_C_DOG_ON:   n.dog_en = 1'b1;
                    `LCDC_C_TONE_OFF: n.tone_en = 1'b0;
                    `LCDC_C_TB_CLR:   n.cnt = '0;
                    `LCDC_C_DOG_CLR:
                    begin
                        n.dog_stg  = '0;
                        n.dog_flag = 1'b0;
                    end
                    default:
                    begin
                    end
                endcase
            end
            else if (c[8:6] == `LCDC_G_BEEP_HI)
            begin
                n.tone_en = 1'b1;
                n.tone_hi = 1'b1;
            end
            else if (c[8:5] == `LCDC_G_BEEP_LO)
            begin
                n.tone_en = 1'b1;
                n.tone_hi = 1'b0;
            end
            else if (c[8:6] == `LCDC_G_EVENT)
            begin
                n.irq_en = c[4];
                if (!c[4])
                begin
                    n.dog_flag = 1'b0;
                end
            end
            else if (c[8:6] == `LCDC_G_RATE && !c[4])
            begin
                n.rate = c[3:1];
            end
            else if (c[8:5] == `LCDC_G_MODE)
            begin
                if (c[4:1] == `LCDC_M_TEST)
                begin
                    n.test = 1'b1;
                end
                else if (c[4:1] == `LCDC_M_NORMAL)
                begin
                    n.test = 1'b0;
                end
            end
        end
        // watchdog: four periods of the selected rate; timeout beats a clear
        n.tb_prev = tb_lvl;
        if (tb_lvl && !s.tb_prev)
        begin
            n.dog_stg = s.dog_stg + 2'h1;
            if (s.dog_stg == `LCDC_DOG_LAST)
            begin
                n.dog_flag = 1'b1;
            end
        end
        n.tone_p = s.tone_en && run &&
                   (s.tone_hi ? s.cnt[`LCDC_BEEP_HI_BIT] : s.cnt[`LCDC_BEEP_LO_BIT]);
        n.tone_n = !n.tone_p;
        n.irq_n  = !(s.irq_en && ((s.tb_en && tb_lvl) || (s.dog_en && s.dog_flag)));
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            s <= ST_RST;
        end
        else
        begin
            s <= n;
        end
    end

    assign data_o    = s.dout;
    assign data_oe_n = s.doe_n;
    assign disp_ram  = s.ram;
    assign disp_on   = s.disp;
    assign osc_run   = s.osc;
    assign test_mode = s.test;
    assign tone_p    = s.tone_p;
    assign tone_n    = s.tone_n;
    assign irq_n     = s.irq_n;
endmodule

`default_nettype wire

// >>> testbench/lcdc_host.sv
// host side model driving the four-wire serial link
`default_nettype none
module lcdc_host (
    // clock
    input  wire logic mclk,
    // serial pins
    output logic      cs_n,
    output logic      wr_n,
    output logic      rd_n,
    output logic      data_i,
    input  wire logic data_o,
    input  wire logic data_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic hen;
    logic hd;
    // pulled-up line: device first, then host, else the resistor
    assign data_i = !data_oe_n ? data_o : (hen ? hd : 1'b1);
    initial
    begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        hen  = 1'b0;
        hd   = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // data held across the strobe rise and after it
    task automatic wbit(input logic b);
        hen  = 1'b1;
        hd   = b;
        wr_n = 1'b0;
        tick(3);
        wr_n = 1'b1;
        tick(3);
    endtask
    task automatic send(input int n, input logic [8:0] v);
        for (int i = n - 1; i >= 0; i--)
            wbit(v[i]);
    endtask
    task automatic start(input logic [2:0] id);
        cs_n = 1'b0;
        tick(2);
        send(3, {6'h00, id});
    endtask
    task automatic stop();
        hen  = 1'b0;
        cs_n = 1'b1;
        tick(12);
    endtask
    task automatic wnib(input logic [3:0] v);
        for (int i = 0; i < 4; i++)
            wbit(v[i]);
    endtask
    task automatic rnib(output logic [3:0] v);
        hen = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            rd_n = 1'b0;
            tick(3);
            v[i] = data_i;
            rd_n = 1'b1;
            tick(3);
        end
    endtask
endmodule
`default_nettype wire

// >>> testbench/lcdc_ctrl_checker.sv
// pin-level assertions for the serial display controller
`default_nettype none
module lcdc_ctrl_checker (
    // clock and reset
    input wire logic         mclk,
    input wire logic         resetn,
    // serial pins
    input wire logic         cs_n,
    input wire logic         wr_n,
    input wire logic         rd_n,
    input wire logic         data_o,
    input wire logic         data_oe_n,
    // clock source
    input wire logic         osc_tick,
    input wire logic         ext_clk_sel,
    // outputs
    input wire logic [255:0] disp_ram,
    input wire logic         disp_on,
    input wire logic         osc_run,
    input wire logic         test_mode,
    input wire logic         tone_p,
    input wire logic         tone_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       wr_q;
    logic [3:0] since_wr;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // cycles since the last write strobe rise, saturating
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_q     <= 1'b1;
            since_wr <= 4'hF;
        end
        else
        begin
            wr_q     <= wr_n;
            since_wr <= (wr_n && !wr_q) ? 4'h0 : since_wr + {3'h0, since_wr != 4'hF};
        end
    end
    sequence cs_idle_s;
        cs_n [*2];
    endsequence
    sequence cs_long_s;
        cs_idle_s ##1 cs_n [*6];
    endsequence
    a_tone_pair: assert property (tone_n == !tone_p)
        else $error("tone outputs not complementary");
    a_release_idle: assert property (cs_idle_s |-> data_oe_n)
        else $error("data driven with select high");
    a_ram_quiet: assert property (cs_long_s |-> $stable(disp_ram))
        else $error("memory changed while deselected");
    a_ext_osc_keep: assert property ($fell(osc_run) |-> !$past(ext_clk_sel))
        else $error("oscillator stopped on external clock");
    a_cfg_cause: assert property ($changed({osc_run, disp_on, test_mode}) |-> since_wr < 4'h8)
        else $error("configuration changed without a strobe");
    a_ram_cause: assert property ($changed(disp_ram) |-> since_wr < 4'h8)
        else $error("memory changed without a strobe");
    a_read_cause: assert property ($changed(data_o) |-> $past(!rd_n) && $past(rd_n, 2))
        else $error("read bit changed without a read fall");
    a_tone_cause: assert property ($changed(tone_p) |->
        $past(osc_tick) || $past(osc_tick, 2) || $past(osc_tick, 3) || since_wr < 4'h8)
        else $error("tone moved without a system tick");
endmodule
bind lcdc_ctrl lcdc_ctrl_checker u_chk (.mclk(mclk), .resetn(resetn), .cs_n(cs_n),
    .wr_n(wr_n), .rd_n(rd_n), .data_o(data_o), .data_oe_n(data_oe_n), .osc_tick(osc_tick),
    .ext_clk_sel(ext_clk_sel), .disp_ram(disp_ram), .disp_on(disp_on), .osc_run(osc_run),
    .test_mode(test_mode), .tone_p(tone_p), .tone_n(tone_n));
`default_nettype wire

// >>> testbench/lcdc_ctrl_tb_top.sv
// self-checking bench for the serial display controller
`default_nettype none
module lcdc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic         mclk, resetn, osc_tick, ext_clk_sel, cs_n, wr_n, rd_n, data_i;
    logic         data_o, data_oe_n, disp_on, osc_run, test_mode, tone_p, tone_n, irq_n;
    logic [255:0] disp_ram;
    logic [3:0]   nib;
    int           fail_count, tests_run, cyc, cnt;
    lcdc_ctrl u_dut (.mclk(mclk), .resetn(resetn), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .data_i(data_i), .data_o(data_o), .data_oe_n(data_oe_n), .osc_tick(osc_tick),
        .ext_clk_sel(ext_clk_sel), .disp_ram(disp_ram), .disp_on(disp_on),
        .osc_run(osc_run), .test_mode(test_mode), .tone_p(tone_p), .tone_n(tone_n),
        .irq_n(irq_n));
    lcdc_host u_host (.mclk(mclk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .data_i(data_i),
        .data_o(data_o), .data_oe_n(data_oe_n));
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // system tick every fourth cycle, plus the run limit
    always @(posedge mclk)
    begin
        #2;
        cyc++;
        osc_tick = (cyc % 4 == 0);
        if (cyc == 40000)
        begin
            fail_count++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [8:0] c);
        u_host.start(3'h4);
        u_host.send(9, c);
        u_host.stop();
    endtask
    // rises of the tone, or falls of the interrupt, over n cycles
    task automatic edges(input logic irq, input int n, output int e);
        logic prev;
        prev = irq ? !irq_n : tone_p;
        e = 0;
        repeat (n)
        begin
            u_host.tick(1);
            if ((irq ? !irq_n : tone_p) && !prev)
                e++;
            prev = irq ? !irq_n : tone_p;
        end
    endtask
    initial
    begin
        {fail_count, tests_run, cyc} = '0;
        {resetn, ext_clk_sel} = 2'h0;
        repeat (2) @(posedge mclk);
        #2;
        resetn = 1'b1;
        chk({disp_on, osc_run, test_mode, tone_p, tone_n, irq_n, data_oe_n}, 32'h7);
        chk({31'h0, |disp_ram}, 32'h0);
        u_host.start(3'h5);
        u_host.send(6, 9'h03E);
        u_host.wnib(4'hA);
        u_host.wnib(4'h5);
        u_host.wnib(4'hC);
        u_host.stop();
        chk(disp_ram[251:248], 4'hA);
        chk(disp_ram[255:252], 4'h5);
        chk(disp_ram[3:0], 4'hC);
        u_host.start(3'h6);
        u_host.send(6, 9'h03F);
        u_host.rnib(nib);
        chk(nib, 4'h5);
        u_host.rnib(nib);
        chk(nib, 4'hC);
        u_host.stop();
        u_host.start(3'h5);
        u_host.send(6, 9'h000);
        u_host.rnib(nib);
        chk(nib, 4'hC);
        u_host.wnib(4'h3);
        u_host.rnib(nib);
        chk(nib, 4'h0);
        u_host.wnib(4'h9);
        u_host.stop();
        chk(disp_ram[7:0], 8'h93);
        u_host.start(3'h5);
        u_host.send(6, 9'h002);
        u_host.send(2, 9'h003);
        u_host.stop();
        chk(disp_ram[11:8], 4'h0);
        u_host.start(3'h5);
        u_host.send(6, 9'h002);
        u_host.wnib(4'h6);
        u_host.stop();
        chk(disp_ram[11:8], 4'h6);
        u_host.start(3'h7);
        u_host.send(6, 9'h002);
        u_host.wnib(4'hF);
        u_host.stop();
        chk(disp_ram[11:8], 4'h6);
        u_host.start(3'h4);
        u_host.send(9, 9'h002);
        u_host.send(9, 9'h006);
        u_host.stop();
        chk({osc_run, disp_on}, 32'h3);
        cmd(9'h004);
        chk(disp_on, 1'b0);
        cmd(9'h000);
        chk(osc_run, 1'b0);
        cmd(9'h1C0);
        chk(test_mode, 1'b1);
        cmd(9'h1C6);
        chk(test_mode, 1'b0);
        ext_clk_sel = 1'b1;
        cmd(9'h002);
        cmd(9'h000);
        chk(osc_run, 1'b1);
        ext_clk_sel = 1'b0;
        cmd(9'h002);
        cmd(9'h080);
        edges(1'b0, 256, cnt);
        chk(cnt, 8);
        cmd(9'h0C0);
        edges(1'b0, 256, cnt);
        chk(cnt, 4);
        cmd(9'h010);
        chk({tone_p, tone_n}, 32'h1);
        cmd(9'h00C);
        cmd(9'h110);
        edges(1'b1, 4096, cnt);
        chk(cnt, 4);
        cmd(9'h14C);
        u_host.tick(2100);
        edges(1'b1, 4096, cnt);
        chk(cnt, 2);
        u_host.start(3'h4);
        u_host.send(9, 9'h008);
        u_host.send(9, 9'h14E);
        u_host.send(9, 9'h00E);
        // count cleared first so no stage step slips in before the stage clear
        u_host.send(9, 9'h01A);
        u_host.send(9, 9'h01E);
        u_host.stop();
        edges(1'b1, 3000, cnt);
        chk({cnt[30:0], irq_n}, 32'h1);
        edges(1'b1, 1300, cnt);
        chk({cnt[30:0], irq_n}, 32'h2);
        cmd(9'h00A);
        chk(irq_n, 1'b1);
        cmd(9'h00E);
        chk(irq_n, 1'b0);
        cmd(9'h100);
        chk(irq_n, 1'b1);
        cmd(9'h110);
        chk(irq_n, 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire
